// ===== asbl_host.sv
// Purpose: host controller that runs read and write cycles on a 64K x 16 static memory
// Assumes: memory pins are driven straight from flops; inputs synchronous to clk_sys
// Notes:   one request at a time; busy high from acceptance until done pulse
// Overview of operation
// - Write only while select, lane, write low
// - Write pulse covers float plus data setup
// - Never drive data while memory drives
// - Write enable stays high during reads
// - Address valid before select and lanes fall
// - Address valid long enough before write end
// - Select low long enough before write end
// - Lane enable low long enough before write end
// - Write data stable before write end
`timescale 1ns/1ps
module asbl_host #(
	parameter int ADDR_W = asbl_pkg::ADDR_W,
	parameter int DATA_W = asbl_pkg::DATA_W
) (
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   req_valid,
	input  wire logic                   req_write,
	input  wire logic [ADDR_W-1:0]      req_addr,
	input  wire logic [DATA_W-1:0]      req_wdata,
	input  wire logic [1:0]             req_lanes,
	output logic                        busy,
	output logic                        done,
	output logic [DATA_W-1:0]           rdata,
	output asbl_pkg::asbl_pins_s        mem_pins,
	output logic [DATA_W-1:0]           mem_dq_out,
	output logic [1:0]                  mem_dq_oe,
	input  wire logic [DATA_W-1:0]      mem_dq_in
);
	// ==========================================================
	// Reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================================
	// Sequencer
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b00_0001,
		ST_RADDR = 6'b00_0010,
		ST_RWAIT = 6'b00_0100,
		ST_WADDR = 6'b00_1000,
		ST_WPULSE = 6'b01_0000,
		ST_WEND  = 6'b10_0000
	} asbl_state_e;

	asbl_state_e state;
	asbl_state_e next_state;
	logic        phase_done;
	logic        phase_load;
	logic [asbl_pkg::CNT_W-1:0] phase_value;
	logic [1:0]  lanes;

	asbl_counter #(
		.W (asbl_pkg::CNT_W)
	) u_phase (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (phase_load),
		.value   (phase_value),
		.done    (phase_done)
	);

	always_comb
	begin
		next_state  = state;
		phase_load  = 1'b0;
		phase_value = asbl_pkg::CNT_ZERO;
		case (state)
			ST_IDLE:
				if (req_valid)
					next_state = req_write ? ST_WADDR : ST_RADDR;
			ST_RADDR:
			begin
				// Address already on the pins, so access runs from select
				next_state  = ST_RWAIT;
				phase_load  = 1'b1;
				phase_value = asbl_pkg::CNT_W'(asbl_pkg::READ_CYC);
			end
			ST_RWAIT:
				if (phase_done)
					next_state = ST_IDLE;
			ST_WADDR:
			begin
				next_state  = ST_WPULSE;
				phase_load  = 1'b1;
				phase_value = asbl_pkg::CNT_W'(asbl_pkg::WRITE_CYC);
			end
			ST_WPULSE:
				if (phase_done)
					next_state = ST_WEND;
			ST_WEND:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// ==========================================================
	// Request capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lanes      <= 2'b00;
			mem_dq_out <= asbl_pkg::DATA_IDLE;
		end
		else if (state == ST_IDLE && req_valid)
		begin
			lanes      <= req_lanes;
			mem_dq_out <= req_wdata;
		end
	end

	// ==========================================================
	// Strobes
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_pins.chip_sel_n          <= 1'b1;
			mem_pins.out_en_n            <= 1'b1;
			mem_pins.write_en_n          <= 1'b1;
			mem_pins.upper_lane_strobe_n <= 1'b1;
			mem_pins.lower_lane_strobe_n <= 1'b1;
			mem_pins.addr                <= asbl_pkg::ADDR_IDLE;
		end
		else
		begin
			// Whole pin bundle has one writer; address leads strobes, holds to end
			if (state == ST_IDLE && req_valid)
				mem_pins.addr <= req_addr;
			// Select and lanes fall with address stable, stay to write end
			mem_pins.chip_sel_n <= !(next_state == ST_RWAIT || next_state == ST_WPULSE);
			mem_pins.lower_lane_strobe_n <= !((next_state == ST_RWAIT ||
				next_state == ST_WPULSE) && lanes[asbl_pkg::LOW_LANE]);
			mem_pins.upper_lane_strobe_n <= !((next_state == ST_RWAIT ||
				next_state == ST_WPULSE) && lanes[asbl_pkg::UP_LANE]);
			// Output enable only in reads, so writes never see memory drive
			mem_pins.out_en_n <= !(next_state == ST_RWAIT);
			// Write enable low only in the pulse, high through reads
			mem_pins.write_en_n <= !(next_state == ST_WPULSE);
		end
	end

	// ==========================================================
	// Data lane drive: on during the write pulse only
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mem_dq_oe <= 2'b00;
		else if (next_state == ST_WPULSE)
			mem_dq_oe <= lanes;
		else
			mem_dq_oe <= 2'b00;
	end

	// ==========================================================
	// Answer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata <= asbl_pkg::DATA_IDLE;
			done  <= 1'b0;
			busy  <= 1'b0;
		end
		else
		begin
			done <= (state == ST_RWAIT && phase_done) || state == ST_WEND;
			busy <= (next_state != ST_IDLE);
			// Sample before strobes rise; unselected lanes read as zero
			if (state == ST_RWAIT && phase_done)
				rdata <= mem_dq_in & {{asbl_pkg::LANE_W{lanes[asbl_pkg::UP_LANE]}},
					{asbl_pkg::LANE_W{lanes[asbl_pkg::LOW_LANE]}}};
		end
	end
endmodule

// ===== asbl_pkg.sv
// Purpose: shared constants and types for the static memory host controller
// Assumes: 200 MHz system clock, 64K x 16 asynchronous memory
// Notes:   timings in ns, cycle counts derived from the clock period
package asbl_pkg;
	// ==========================================================
	// Geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam int LANES  = 2;
	localparam int LOW_LANE = 0;
	localparam int UP_LANE  = 1;

	// ==========================================================
	// Timing, slower grade figures so both grades are met
	localparam int CLK_PERIOD_PS        = 5000;
	localparam int ADDR_ACCESS_NS       = 20;
	localparam int OE_ACCESS_NS         = 10;
	localparam int LANE_ACCESS_NS       = 10;
	localparam int WE_FLOAT_NS          = 8;
	localparam int DATA_SETUP_TO_WRITE_END_NS = 10;
	localparam int WRITE_STROBE_NS      = 12;
	localparam int OE_FLOAT_NS          = 8;
	localparam int PS_PER_NS            = 1000;

	function automatic int cyc_up(input int ns);
		return (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	endfunction

	localparam int READ_CYC  = cyc_up(ADDR_ACCESS_NS) + 1;
	localparam int FLOAT_CYC = cyc_up(OE_FLOAT_NS);
	localparam int SETUP_CYC = cyc_up(DATA_SETUP_TO_WRITE_END_NS);
	localparam int STROBE_CYC_RAW = cyc_up(WRITE_STROBE_NS);
	localparam int WRITE_CYC = (STROBE_CYC_RAW > FLOAT_CYC + SETUP_CYC) ?
		STROBE_CYC_RAW : FLOAT_CYC + SETUP_CYC;
	localparam int CNT_W = 4;

	// ==========================================================
	// Pin bundle toward the memory
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              chip_sel_n;
		logic              out_en_n;
		logic              write_en_n;
		logic              upper_lane_strobe_n;
		logic              lower_lane_strobe_n;
	} asbl_pins_s;

	localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;
endpackage

// ===== asbl_counter.sv
// Purpose: down counter that times one memory phase
// Assumes: load and count are never asserted together with reset
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module asbl_counter #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	logic [W-1:0] count;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else if (load)
			count <= value;
		else if (count != '0)
			count <= count - 1'b1;
	end

	assign done = (count == '0);
endmodule

// ===== asbl_host_properties.sv
// Purpose: pin timing checks for the static memory host
// Assumes: single clock, nrst active low
// Notes:   cycle counts follow the hand-over walk
`timescale 1ns/1ps
module asbl_host_chk (
	input wire logic                 clk_sys,
	input wire logic                 nrst,
	input wire logic                 done,
	input wire asbl_pkg::asbl_pins_s mem_pins,
	input wire logic [15:0]          mem_dq_out,
	input wire logic [1:0]           mem_dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Write and read phases
	sequence wr_held;
		(!mem_pins.write_en_n && !mem_pins.chip_sel_n)[*5];
	endsequence
	// Strobes rise first, done follows one cycle later
	sequence wr_end;
		(mem_pins.write_en_n && mem_pins.chip_sel_n && mem_dq_oe == 2'b00) ##1 done;
	endsequence
	sequence rd_held;
		(!mem_pins.out_en_n && !mem_pins.chip_sel_n)[*6];
	endsequence
	chk_write_pulse_len: assert property (
		$fell(mem_pins.write_en_n) |-> wr_held ##1 wr_end) else $error("write pulse length");
	chk_write_start: assert property (
		$fell(mem_pins.write_en_n) |-> $fell(mem_pins.chip_sel_n)) else $error("write start");
	chk_read_no_write: assert property (
		!mem_pins.out_en_n |-> mem_pins.write_en_n && mem_dq_oe == 2'b00) else $error("read drive");
	chk_lane_map: assert property (
		!mem_pins.write_en_n |-> mem_dq_oe ==
		~{mem_pins.upper_lane_strobe_n, mem_pins.lower_lane_strobe_n}) else $error("lane map");
	chk_write_data_stable: assert property (
		!mem_pins.write_en_n && !$past(mem_pins.write_en_n) |->
		$stable(mem_dq_out) && $stable(mem_pins.addr)) else $error("write data moved");
	chk_read_len: assert property (
		$fell(mem_pins.out_en_n) |-> rd_held ##1 (mem_pins.out_en_n && done))
		else $error("read length");
	chk_addr_first: assert property (
		$fell(mem_pins.chip_sel_n) |-> $stable(mem_pins.addr)) else $error("addr late");
	chk_idle_quiet: assert property (
		mem_pins.chip_sel_n |-> mem_dq_oe == 2'b00 && mem_pins.write_en_n)
		else $error("idle drive");
endmodule
bind asbl_host asbl_host_chk chk_u (.clk_sys(clk_sys), .nrst(nrst), .done(done),
	.mem_pins(mem_pins), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// ===== asbl_sram_model.sv
// Purpose: behavioural 64K x 16 static memory
// Assumes: pins straight from the host
// Notes:   floating lanes show inverted data, never a stale copy
`timescale 1ns/1ps
module asbl_sram_model #(
	parameter int ACC_NS = 20
) (
	input wire asbl_pkg::asbl_pins_s pins,
	input wire logic [15:0]          dq_out,
	input wire logic [1:0]           dq_oe,
	output logic [15:0]              dq_in
);
	logic [15:0] mem [0:65535];
	logic [1:0]  lane_n;
	logic [1:0]  rd;
	logic [15:0] word;
	assign lane_n = {pins.upper_lane_strobe_n, pins.lower_lane_strobe_n};
	// No clock: stores during the overlap of the strobes
	always @*
	begin
		for (int i = 0; i < 2; i++)
			if (!pins.chip_sel_n && !pins.write_en_n && !lane_n[i] && dq_oe[i])
				mem[pins.addr][i*8 +: 8] = dq_out[i*8 +: 8];
	end
	assign rd = (!pins.chip_sel_n && !pins.out_en_n && pins.write_en_n) ? ~lane_n : 2'b00;
	assign word = mem[pins.addr];
	// Inertial delay models access time and hold of old data
	assign #(ACC_NS) dq_in = {rd[1] ? word[15:8] : ~word[15:8],
		rd[0] ? word[7:0] : ~word[7:0]};
endmodule

// ===== async_sram_byte_lane_access_tb_top.sv
// Purpose: self-checking bench for the static memory host
// Assumes: inputs driven on falling edges
// Notes:   memory model answers at the slow access time
`timescale 1ns/1ps
module async_sram_byte_lane_access_tb_top;
	logic                 clk_sys = 1'b0;
	logic                 nrst = 1'b0;
	logic                 req_valid = 1'b0;
	logic                 req_write = 1'b0;
	logic [15:0]          req_addr = 16'h0000;
	logic [15:0]          req_wdata = 16'h0000;
	logic [1:0]           req_lanes = 2'b00;
	logic                 busy;
	logic                 done;
	logic [15:0]          rdata;
	logic [15:0]          mem_dq_out;
	logic [15:0]          mem_dq_in;
	logic [1:0]           mem_dq_oe;
	asbl_pkg::asbl_pins_s mem_pins;
	int                   num_errors = 0;
	int                   checked = 0;
	always #2.5 clk_sys = ~clk_sys;
	asbl_host dut_u (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_lanes(req_lanes), .busy(busy), .done(done), .rdata(rdata), .mem_pins(mem_pins),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
	asbl_sram_model mem_u (.pins(mem_pins), .dq_out(mem_dq_out), .dq_oe(mem_dq_oe),
		.dq_in(mem_dq_in));
	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic op(input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] ln, output logic [15:0] q, output int n);
		n = 0;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		req_lanes = ln;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		while (done !== 1'b1 && n < 20)
		begin
			@(negedge clk_sys);
			n++;
		end
		q = rdata;
	endtask
	task automatic finish_test;
		$display("Errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_word;
		logic [15:0] q;
		int          n;
		op(1'b1, 16'hFFFF, 16'hA5C3, 2'b11, q, n);
		check(n, asbl_pkg::WRITE_CYC + 3);
		op(1'b1, 16'h0000, 16'h5A3C, 2'b11, q, n);
		op(1'b0, 16'hFFFF, 16'h0000, 2'b11, q, n);
		check(n, asbl_pkg::READ_CYC + 2);
		check(q, 16'hA5C3);
		op(1'b0, 16'h0000, 16'h0000, 2'b11, q, n);
		check(q, 16'h5A3C);
	endtask
	task automatic t_lanes;
		logic [15:0] q;
		int          n;
		op(1'b1, 16'h0010, 16'hBEEF, 2'b11, q, n);
		op(1'b1, 16'h0010, 16'h7712, 2'b01, q, n);
		op(1'b1, 16'h0011, 16'hCAFE, 2'b11, q, n);
		op(1'b1, 16'h0011, 16'h7755, 2'b10, q, n);
		op(1'b0, 16'h0010, 16'h0000, 2'b11, q, n);
		check(q, 16'hBE12);
		op(1'b0, 16'h0011, 16'h0000, 2'b11, q, n);
		check(q, 16'h77FE);
		op(1'b0, 16'h0010, 16'h0000, 2'b10, q, n);
		check(q, 16'hBE00);
		op(1'b0, 16'h0011, 16'h0000, 2'b01, q, n);
		check(q, 16'h00FE);
	endtask
	task automatic t_busy;
		logic [15:0] q;
		int          n;
		op(1'b1, 16'h0021, 16'h0000, 2'b11, q, n);
		req_write = 1'b1;
		req_addr = 16'h0020;
		req_wdata = 16'h1234;
		req_lanes = 2'b11;
		req_valid = 1'b1;
		@(negedge clk_sys);
		check(busy, 1'b1);
		// A request held up while busy must be ignored
		req_addr = 16'h0021;
		req_wdata = 16'hDEAD;
		repeat (6) @(negedge clk_sys);
		check({busy, done}, 2'b10);
		req_valid = 1'b0;
		@(negedge clk_sys);
		check({busy, done}, 2'b01);
		@(negedge clk_sys);
		check(done, 1'b0);
		op(1'b0, 16'h0020, 16'h0000, 2'b11, q, n);
		check(q, 16'h1234);
		op(1'b0, 16'h0021, 16'h0000, 2'b11, q, n);
		check(q, 16'h0000);
	endtask
	initial
	begin
		#20000;
		num_errors++;
		finish_test;
	end
	initial
	begin
		repeat (12) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		check({mem_pins.chip_sel_n, mem_pins.write_en_n, mem_dq_oe}, 4'b1100);
		t_word;
		t_lanes;
		t_busy;
		finish_test;
	end
endmodule
